/* bench/charger_event_status_regs_sva.sv */
// concurrent checks on the charger register bank ports
// assumes the host holds every serial clock phase for four or more clocks
module charger_event_status_regs_sva (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // bus pins
    input wire logic i_scl,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    // status inputs
    input wire logic i_precharge_timer_expired,
    input wire logic i_total_timer_expired,
    input wire logic i_batt_temp_in_window,
    input wire logic i_supply_valid,
    input wire logic i_charge_done,
    // outputs
    input wire logic o_switch_a_enable,
    input wire logic o_switch_b_enable,
    input wire logic o_switch_c_enable,
    input wire logic o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic [3:0] lo_cnt;
    logic [3:0] hi_cnt;
    logic [3:0] quiet_cnt;
    logic [4:0] st_prev;
    wire logic [4:0] st = {i_precharge_timer_expired, i_total_timer_expired,
        i_batt_temp_in_window, i_supply_valid, i_charge_done};
    wire logic [2:0] sw = {o_switch_a_enable, o_switch_b_enable,
        o_switch_c_enable};
    // saturating counts keep the helpers narrow
    always_ff @(posedge i_clk or negedge i_reset_n)
        if (!i_reset_n)
            lo_cnt <= 4'h0;
        else
            lo_cnt <= i_scl ? 4'h0 : lo_cnt + {3'h0, lo_cnt != 4'hf};
    always_ff @(posedge i_clk or negedge i_reset_n)
        if (!i_reset_n)
            hi_cnt <= 4'h0;
        else
            hi_cnt <= !i_scl ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hf};
    always_ff @(posedge i_clk or negedge i_reset_n)
        if (!i_reset_n)
            st_prev <= 5'h00;
        else
            st_prev <= st;
    always_ff @(posedge i_clk or negedge i_reset_n)
        if (!i_reset_n)
            quiet_cnt <= 4'h0;
        else if (st != st_prev)
            quiet_cnt <= 4'h0;
        else
            quiet_cnt <= quiet_cnt + {3'h0, quiet_cnt != 4'hf};
    sequence scl_two_high;
        i_scl [*2];
    endsequence
    a_sda_low_only: assert property (o_sda_out == 1'b0)
        else $error("data pin driven high");
    a_ack_answer_time: assert property (
        $rose(o_sda_oe) |-> lo_cnt inside {[2:6]})
        else $error("data drive not 2..6 clocks after clock fall");
    a_idle_bus_free: assert property (hi_cnt >= 4'ha |-> !o_sda_oe)
        else $error("data pulled low on idle bus");
    a_oe_hold_high: assert property (scl_two_high |-> $stable(o_sda_oe))
        else $error("data drive changed while clock high");
    a_switch_hold_high: assert property (scl_two_high |-> $stable(sw))
        else $error("switch changed while clock high");
    a_irq_clear_bus: assert property (
        $fell(o_irq) |-> lo_cnt inside {[2:7]})
        else $error("irq fell outside a bus access");
    a_irq_has_cause: assert property (
        $rose(o_irq) |-> quiet_cnt <= 4'h8)
        else $error("irq rose with no status change");
    a_reset_quiet_out: assert property (@(posedge i_clk)
        disable iff (1'b0) !i_reset_n |-> !o_irq && !o_sda_oe && sw == 3'h0)
        else $error("outputs active in reset");
endmodule
bind charger_event_status_regs charger_event_status_regs_sva chk_u (
    .i_clk, .i_reset_n, .i_scl, .o_sda_out, .o_sda_oe,
    .i_precharge_timer_expired, .i_total_timer_expired,
    .i_batt_temp_in_window, .i_supply_valid, .i_charge_done,
    .o_switch_a_enable, .o_switch_b_enable, .o_switch_c_enable, .o_irq
);

/* bench/host_master.sv */
// host processor model: serial bus master for register access
// assumes a pull-up on the data wire; data moves with clock low except at start and stop
module host_master (
    // clock
    input wire logic i_clk,
    // bus pins
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_byte;
    logic acked;
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        tick(4);
        o_sda = b;
        tick(3);
        o_scl = 1'b1;
        tick(4);
        r = i_sda;
        tick(1);
        o_scl = 1'b0;
    endtask
    // start when lvl is 1, stop when 0; the clock idles high after stop
    task automatic edge_cond(input logic lvl);
        tick(4);
        o_sda = lvl;
        tick(3);
        o_scl = 1'b1;
        tick(5);
        o_sda = !lvl;
        tick(5);
        o_scl = !lvl;
    endtask
    task automatic send(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        acked = acked & !r;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] ofs,
                      input logic [7:0] d);
        acked = 1'b1;
        edge_cond(1'b1);
        send({a, 1'b0});
        send(ofs);
        send(d);
        edge_cond(1'b0);
    endtask
    task automatic rd(input logic [7:0] ofs);
        logic r;
        acked = 1'b1;
        edge_cond(1'b1);
        send({charger_pkg::SLAVE_ADDR, 1'b0});
        send(ofs);
        edge_cond(1'b1);
        send({charger_pkg::SLAVE_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, rx_byte[i]);
        bit_io(1'b1, r);
        edge_cond(1'b0);
    endtask
endmodule

/* bench/testbench.sv */
// self-checking bench for the charger event and status register bank
// assumes the host model on the bus pins and the bound checker
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // reset falls on the first clock fall, so no rising edge sees unknowns
    logic i_clk = 1'b1;
    logic i_reset_n = 1'b1;
    logic [4:0] st = 5'h02; // pre, total, temp, supply, done
    logic [5:0] misc = 6'h01; // adapter, host, phase, cursel, good
    logic scl;
    logic m_sda;
    logic sda_out;
    logic sda_oe;
    logic irq;
    logic [2:0] sw;
    logic [7:0] arm;
    wire logic sda_w = m_sda & ~sda_oe;
    int tests_run = 0;
    int mismatches = 0;
    logic [7:0] pat [2] = '{8'ha5, 8'h5a};
    logic [7:0] swp [4] = '{8'he0, 8'h50, 8'h20, 8'h90};
    logic [7:0] srcp [4] = '{8'h81, 8'h50, 8'h31, 8'h00};
    logic [4:0] stp [5] = '{5'h1d, 5'h1f, 5'h0a, 5'h13, 5'h02};
    int idx [8] = '{0, 1, 2, 4, 0, 1, 2, 3};
    always #20 i_clk = ~i_clk;
    charger_event_status_regs dut_u (
        .i_clk, .i_reset_n, .i_scl(scl), .i_sda(sda_w),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_precharge_timer_expired(st[4]), .i_total_timer_expired(st[3]),
        .i_batt_temp_in_window(st[2]), .i_supply_valid(st[1]),
        .i_charge_done(st[0]), .i_adapter_source(misc[5]),
        .i_host_port_source(misc[4]), .i_charging_phase_code(misc[3:2]),
        .i_current_select_pin(misc[1]), .i_switch_a_good(misc[0]),
        .o_switch_a_enable(sw[2]), .o_switch_b_enable(sw[1]),
        .o_switch_c_enable(sw[0]), .o_irq(irq));
    host_master host_u (.i_clk, .i_sda(sda_w), .o_scl(scl), .o_sda(m_sda));
    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rdc(input logic [7:0] ofs, input logic [7:0] exp,
                       input string name);
        host_u.rd(ofs);
        chk(name, host_u.rx_byte, exp);
    endtask
    task automatic w(input logic [7:0] ofs, input logic [7:0] d);
        host_u.wr(charger_pkg::SLAVE_ADDR, ofs, d);
    endtask
    // irq is a level, so a fixed settle then one look is enough
    task automatic irq_is(input logic exp);
        repeat (20) @(negedge i_clk);
        chk("irq", {7'h0, irq}, {7'h0, exp});
    endtask
    function automatic logic [7:0] live();
        return {4'h0, st[1] & (st[4] | st[3]), st[1] & st[2], st[1],
            st[1] & st[0]};
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        @(negedge i_clk);
        i_reset_n = 1'b0;
        repeat (12) @(negedge i_clk);
        i_reset_n = 1'b1;
        repeat (8) @(negedge i_clk);
        rdc(8'ha9, 8'h00, "ctrl reset");
        rdc(8'ha8, live(), "status reset");
        rdc(8'hab, 8'h00, "unmapped");
        $display("test reset done");
        foreach (pat[i])
        begin
            w(8'ha9, pat[i]);
            rdc(8'ha9, pat[i], "ctrl rw");
        end
        host_u.wr(7'h2d, 8'ha9, 8'hff);
        chk("wrong addr ack", {7'h0, host_u.acked}, 8'h00);
        rdc(8'ha9, 8'h5a, "ctrl kept");
        w(8'ha9, 8'h00);
        $display("test control done");
        foreach (swp[i])
        begin
            misc[0] = swp[i][4];
            w(8'hb0, swp[i] | 8'h1f);
            chk("switch pins", {5'h0, sw}, {5'h0, swp[i][7:5]});
            rdc(8'hb0, swp[i], "switch reg");
        end
        $display("test switch done");
        foreach (srcp[i])
        begin
            misc[5:1] = {srcp[i][7:4], srcp[i][0]};
            w(8'haa, ~srcp[i]);
            rdc(8'haa, srcp[i], "source reg");
        end
        $display("test source done");
        foreach (stp[i])
        begin
            st = stp[i];
            rdc(8'ha8, live(), "live status");
        end
        $display("test status done");
        // walk every direction enable; the opposite edge must stay quiet
        for (int k = 0; k < 8; k++)
        begin
            arm = 8'h10 << (idx[k] > 3 ? 3 : idx[k]);
            st[idx[k]] = (k >= 3);
            w(8'ha9, 8'h01 << k);
            w(8'ha8, arm);
            st[idx[k]] = (k < 3);
            irq_is(1'b0);
            st[idx[k]] = (k >= 3);
            irq_is(1'b1);
            rdc(8'ha8, arm | live(), "pending");
            irq_is(1'b0);
            rdc(8'ha8, live(), "cleared");
            w(8'ha8, 8'h00);
            w(8'ha9, 8'h00);
            st = 5'h02;
            $display("test event %0d done", k);
        end
        st = 5'h00;
        w(8'ha9, 8'h80);
        w(8'ha8, 8'h80);
        st = 5'h08;
        irq_is(1'b0);
        rdc(8'ha8, 8'h00, "gated timer");
        w(8'ha8, 8'h00);
        w(8'ha9, 8'h00);
        st = 5'h02;
        $display("test gating done");
        print_verdict();
    end
endmodule

/* common/charger_pkg.sv */
// constants for the charger event and status register bank
// assumes a single system clock and a serial two-wire host port
package charger_pkg;

    // serial slave address, 7 bits; a neutral value, change per board
    localparam logic [6:0] SLAVE_ADDR = 7'h5a;

    // register offsets
    localparam logic [7:0] CHARGER_EVENT_STATUS_OFS = 8'ha8;
    localparam logic [7:0] CHARGER_INTERRUPT_CONTROL_OFS = 8'ha9;
    localparam logic [7:0] CHARGER_SOURCE_STATE_OFS = 8'haa;
    localparam logic [7:0] POWER_SWITCH_CONTROL_OFS = 8'hb0;

    // reset values
    localparam logic [3:0] EVENT_ARM_RESET = 4'h0;
    localparam logic [3:0] EVENT_PENDING_RESET = 4'h0;
    localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;
    localparam logic [2:0] SWITCH_ENABLE_RESET = 3'h0;

    // event flag positions inside the pending/arm nibble (bits 7..4)
    localparam int SAFETY_TIMER_EVENT_BIT = 3;
    localparam int BATT_TEMP_EVENT_BIT = 2;
    localparam int SUPPLY_EVENT_BIT = 1;
    localparam int CHARGE_PHASE_EVENT_BIT = 0;

    // interrupt control field positions
    localparam int TOTAL_TIMER_IRQ_EN_BIT = 7;
    localparam int BATT_TEMP_ENTER_IRQ_EN_BIT = 6;
    localparam int SUPPLY_VALID_IRQ_EN_BIT = 5;
    localparam int CHARGE_DONE_ENTER_IRQ_EN_BIT = 4;
    localparam int PRECHARGE_TIMER_IRQ_EN_BIT = 3;
    localparam int BATT_TEMP_LEAVE_IRQ_EN_BIT = 2;
    localparam int SUPPLY_LOST_IRQ_EN_BIT = 1;
    localparam int CHARGE_DONE_EXIT_IRQ_EN_BIT = 0;

    // positions in the synchroniser vector
    localparam int SYNC_WIDTH = 13;
    localparam int S_PRE_EXP = 0;
    localparam int S_TOT_EXP = 1;
    localparam int S_TEMP_OK = 2;
    localparam int S_SUPPLY = 3;
    localparam int S_DONE = 4;
    localparam int S_ADAPTER = 5;
    localparam int S_HOSTPORT = 6;
    localparam int S_PHASE_LO = 7;
    localparam int S_PHASE_HI = 8;
    localparam int S_CUR_SEL = 9;
    localparam int S_SW_A_GOOD = 10;
    localparam int S_SCL = 11;
    localparam int S_SDA = 12;

    // serial slave bit count per byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } serial_state_type;

endpackage

/* logic/charger_event_status_regs.sv */
// charger event/status registers and switch enables behind a serial slave
// assumes status inputs and bus pins are asynchronous to i_clk
//
// Behaviour
// - bit 6 arms battery temperature events, reads pending
// - bit 5 arms supply voltage events, reads pending
// - bit 4 arms end-of-charge entry/exit events
// - bit 3 reads either safety timer expired
// - bit 2 reads battery temperature inside window
// - bit 1 reads valid supply at input pin
// - bit 0 reads charger in end-of-charge
// - control bit 7 enables total timer interrupt
// - control bit 6 enables temperature-enter interrupt
// - control bit 5 enables supply-valid interrupt
// - control bit 4 enables end-of-charge entry interrupt
// - control bit 3 enables precharge timer interrupt
// - control bit 2 enables temperature-leave interrupt
// - control bit 1 enables supply-lost interrupt
// - control bit 0 enables end-of-charge exit interrupt
// - source bit 7 reads adapter charging
// - source bit 6 reads host-port charging
// - bits 5:4 charging phase, 3:1 reserved zero
// - source bit 0 mirrors current select pin
// - switch bits 7..5 turn switches on/off
// - switch bit 4 reads first switch good
// - charger flags valid only with valid supply
module charger_event_status_regs (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // serial bus pins, data is open drain
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // charger status inputs
    input wire logic i_precharge_timer_expired,
    input wire logic i_total_timer_expired,
    input wire logic i_batt_temp_in_window,
    input wire logic i_supply_valid,
    input wire logic i_charge_done,
    input wire logic i_adapter_source,
    input wire logic i_host_port_source,
    input wire logic [1:0] i_charging_phase_code,
    input wire logic i_current_select_pin,
    input wire logic i_switch_a_good,
    // outputs
    output logic o_switch_a_enable,
    output logic o_switch_b_enable,
    output logic o_switch_c_enable,
    output logic o_irq
);

    // byte address decode, shared by read mux and write path
    function automatic logic is_addr(input logic [7:0] a,
                                     input logic [7:0] ofs);
        is_addr = (a == ofs);
    endfunction

    logic [charger_pkg::SYNC_WIDTH-1:0] sync1_reg;
    logic [charger_pkg::SYNC_WIDTH-1:0] sync2_reg;
    logic [charger_pkg::SYNC_WIDTH-1:0] async_in;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic [4:0] stat_prev_reg;

    assign async_in = {i_sda, i_scl, i_switch_a_good, i_current_select_pin,
                       i_charging_phase_code, i_host_port_source,
                       i_adapter_source, i_charge_done, i_supply_valid,
                       i_batt_temp_in_window, i_total_timer_expired,
                       i_precharge_timer_expired};

    // two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic scl;
    logic sda;
    logic supply_ok;
    logic timer_exp;
    logic temp_ok;
    logic done;
    assign scl = sync2_reg[charger_pkg::S_SCL];
    assign sda = sync2_reg[charger_pkg::S_SDA];
    assign supply_ok = sync2_reg[charger_pkg::S_SUPPLY];
    assign timer_exp = sync2_reg[charger_pkg::S_PRE_EXP] |
                       sync2_reg[charger_pkg::S_TOT_EXP];
    assign temp_ok = sync2_reg[charger_pkg::S_TEMP_OK];
    assign done = sync2_reg[charger_pkg::S_DONE];

    // history for edge detection, taken from the second stage
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            stat_prev_reg <= '0;
        end
        else
        begin
            scl_prev_reg <= scl;
            sda_prev_reg <= sda;
            stat_prev_reg <= sync2_reg[4:0];
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    assign scl_rise = scl & ~scl_prev_reg;
    assign scl_fall = ~scl & scl_prev_reg;
    assign start_seen = scl & scl_prev_reg & sda_prev_reg & ~sda;
    assign stop_seen = scl & scl_prev_reg & ~sda_prev_reg & sda;

    // registers
    logic [3:0] arm_reg;
    logic [3:0] pending_reg;
    logic [7:0] irq_ctrl_reg;
    logic [2:0] switch_en_reg;
    logic irq_reg;

    // pulses from the serial slave
    logic wr_stb_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic rd_event_stb_reg;

    // live status nibble; charger flags masked without valid supply
    logic [3:0] live_status;
    assign live_status = {timer_exp & supply_ok,
                          temp_ok & supply_ok,
                          supply_ok,
                          done & supply_ok};

    function automatic logic [7:0] read_mux(input logic [7:0] a,
                                            input logic [3:0] pend,
                                            input logic [3:0] live,
                                            input logic [7:0] ctrl,
                                            input logic [7:0] srcv,
                                            input logic [2:0] sw,
                                            input logic good);
        read_mux = 8'h00;
        if (is_addr(a, charger_pkg::CHARGER_EVENT_STATUS_OFS))
            read_mux = {pend, live};
        else if (is_addr(a, charger_pkg::CHARGER_INTERRUPT_CONTROL_OFS))
            read_mux = ctrl;
        else if (is_addr(a, charger_pkg::CHARGER_SOURCE_STATE_OFS))
            read_mux = srcv;
        else if (is_addr(a, charger_pkg::POWER_SWITCH_CONTROL_OFS))
            read_mux = {sw, good, 4'h0};
    endfunction

    logic [7:0] source_value;
    assign source_value = {sync2_reg[charger_pkg::S_ADAPTER],
                           sync2_reg[charger_pkg::S_HOSTPORT],
                           sync2_reg[charger_pkg::S_PHASE_HI:
                                     charger_pkg::S_PHASE_LO],
                           3'h0,
                           sync2_reg[charger_pkg::S_CUR_SEL]};

    // serial slave
    charger_pkg::serial_state_type state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic read_mode_reg;
    logic master_ack_reg;
    logic [7:0] rd_value;
    assign rd_value = read_mux(ptr_reg, pending_reg, live_status,
                               irq_ctrl_reg, source_value, switch_en_reg,
                               sync2_reg[charger_pkg::S_SW_A_GOOD]);

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg <= charger_pkg::ST_IDLE;
            bit_cnt_reg <= '0;
            shift_reg <= '0;
            tx_reg <= '0;
            ptr_reg <= '0;
            read_mode_reg <= 1'b0;
            master_ack_reg <= 1'b0;
            o_sda_oe <= 1'b0;
            wr_stb_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
            rd_event_stb_reg <= 1'b0;
        end
        else
        begin
            wr_stb_reg <= 1'b0;
            rd_event_stb_reg <= 1'b0;
            if (start_seen)
            begin
                state_reg <= charger_pkg::ST_ADDR;
                bit_cnt_reg <= '0;
                o_sda_oe <= 1'b0;
            end
            else if (stop_seen)
            begin
                state_reg <= charger_pkg::ST_IDLE;
                o_sda_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                shift_reg <= {shift_reg[6:0], sda};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (state_reg == charger_pkg::ST_RDATA_ACK)
                    master_ack_reg <= ~sda;
            end
            else if (scl_fall)
            begin
                case (state_reg)
                    charger_pkg::ST_ADDR:
                        if (bit_cnt_reg == charger_pkg::BITS_PER_BYTE)
                        begin
                            if (shift_reg[7:1] == charger_pkg::SLAVE_ADDR)
                            begin
                                read_mode_reg <= shift_reg[0];
                                o_sda_oe <= 1'b1;
                                state_reg <= charger_pkg::ST_ADDR_ACK;
                            end
                            else
                                state_reg <= charger_pkg::ST_IDLE;
                        end
                    charger_pkg::ST_PTR:
                        if (bit_cnt_reg == charger_pkg::BITS_PER_BYTE)
                        begin
                            ptr_reg <= shift_reg;
                            o_sda_oe <= 1'b1;
                            state_reg <= charger_pkg::ST_PTR_ACK;
                        end
                    charger_pkg::ST_WDATA:
                        if (bit_cnt_reg == charger_pkg::BITS_PER_BYTE)
                        begin
                            wr_stb_reg <= 1'b1;
                            wr_addr_reg <= ptr_reg;
                            wr_data_reg <= shift_reg;
                            ptr_reg <= ptr_reg + 8'h01;
                            o_sda_oe <= 1'b1;
                            state_reg <= charger_pkg::ST_WDATA_ACK;
                        end
                    charger_pkg::ST_PTR_ACK,
                    charger_pkg::ST_WDATA_ACK:
                    begin
                        o_sda_oe <= 1'b0;
                        bit_cnt_reg <= '0;
                        state_reg <= charger_pkg::ST_WDATA;
                    end
                    charger_pkg::ST_ADDR_ACK,
                    charger_pkg::ST_RDATA_ACK:
                    begin
                        bit_cnt_reg <= '0;
                        if (state_reg == charger_pkg::ST_ADDR_ACK &&
                            !read_mode_reg)
                        begin
                            o_sda_oe <= 1'b0;
                            state_reg <= charger_pkg::ST_PTR;
                        end
                        else if (state_reg == charger_pkg::ST_ADDR_ACK ||
                                 master_ack_reg)
                        begin
                            // reading the event register consumes pending
                            tx_reg <= rd_value;
                            o_sda_oe <= ~rd_value[7];
                            rd_event_stb_reg <= is_addr(ptr_reg,
                                charger_pkg::CHARGER_EVENT_STATUS_OFS);
                            ptr_reg <= ptr_reg + 8'h01;
                            state_reg <= charger_pkg::ST_RDATA;
                        end
                        else
                        begin
                            o_sda_oe <= 1'b0;
                            state_reg <= charger_pkg::ST_IDLE;
                        end
                    end
                    charger_pkg::ST_RDATA:
                        if (bit_cnt_reg == charger_pkg::BITS_PER_BYTE)
                        begin
                            o_sda_oe <= 1'b0;
                            state_reg <= charger_pkg::ST_RDATA_ACK;
                        end
                        else
                        begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            o_sda_oe <= ~tx_reg[6];
                        end
                    default:
                        o_sda_oe <= 1'b0;
                endcase
            end
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_sda_out <= 1'b0;
        else
            o_sda_out <= 1'b0;
    end

    logic wr_event;
    logic wr_ctrl;
    logic wr_switch;
    assign wr_event = wr_stb_reg &
        is_addr(wr_addr_reg, charger_pkg::CHARGER_EVENT_STATUS_OFS);
    assign wr_ctrl = wr_stb_reg &
        is_addr(wr_addr_reg, charger_pkg::CHARGER_INTERRUPT_CONTROL_OFS);
    assign wr_switch = wr_stb_reg &
        is_addr(wr_addr_reg, charger_pkg::POWER_SWITCH_CONTROL_OFS);

    // control and arm bits; read-only bits ignore writes
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            arm_reg <= charger_pkg::EVENT_ARM_RESET;
            irq_ctrl_reg <= charger_pkg::IRQ_CONTROL_RESET;
            switch_en_reg <= charger_pkg::SWITCH_ENABLE_RESET;
        end
        else
        begin
            if (wr_event)
                arm_reg <= wr_data_reg[7:4];
            if (wr_ctrl)
                irq_ctrl_reg <= wr_data_reg;
            if (wr_switch)
                switch_en_reg <= wr_data_reg[7:5];
        end
    end

    // event detection against the previous status sample
    logic [3:0] event_hit;
    logic [4:0] rise;
    logic [4:0] fall;
    assign rise = sync2_reg[4:0] & ~stat_prev_reg;
    assign fall = ~sync2_reg[4:0] & stat_prev_reg;

    always_comb
    begin
        event_hit[charger_pkg::SAFETY_TIMER_EVENT_BIT] = supply_ok &
            ((rise[charger_pkg::S_TOT_EXP] &
              irq_ctrl_reg[charger_pkg::TOTAL_TIMER_IRQ_EN_BIT]) |
             (rise[charger_pkg::S_PRE_EXP] &
              irq_ctrl_reg[charger_pkg::PRECHARGE_TIMER_IRQ_EN_BIT]));
        event_hit[charger_pkg::BATT_TEMP_EVENT_BIT] = supply_ok &
            ((rise[charger_pkg::S_TEMP_OK] &
              irq_ctrl_reg[charger_pkg::BATT_TEMP_ENTER_IRQ_EN_BIT]) |
             (fall[charger_pkg::S_TEMP_OK] &
              irq_ctrl_reg[charger_pkg::BATT_TEMP_LEAVE_IRQ_EN_BIT]));
        event_hit[charger_pkg::SUPPLY_EVENT_BIT] =
            (rise[charger_pkg::S_SUPPLY] &
             irq_ctrl_reg[charger_pkg::SUPPLY_VALID_IRQ_EN_BIT]) |
            (fall[charger_pkg::S_SUPPLY] &
             irq_ctrl_reg[charger_pkg::SUPPLY_LOST_IRQ_EN_BIT]);
        event_hit[charger_pkg::CHARGE_PHASE_EVENT_BIT] = supply_ok &
            ((rise[charger_pkg::S_DONE] &
              irq_ctrl_reg[charger_pkg::CHARGE_DONE_ENTER_IRQ_EN_BIT]) |
             (fall[charger_pkg::S_DONE] &
              irq_ctrl_reg[charger_pkg::CHARGE_DONE_EXIT_IRQ_EN_BIT]));
    end

    // pending flags: a new event beats a clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_pending
            always_ff @(posedge i_clk or negedge i_reset_n)
            begin
                if (!i_reset_n)
                    pending_reg[g] <= charger_pkg::EVENT_PENDING_RESET[g];
                else if (event_hit[g] & arm_reg[g])
                    pending_reg[g] <= 1'b1;
                else if (rd_event_stb_reg | (wr_event & ~wr_data_reg[g + 4]))
                    pending_reg[g] <= 1'b0;
            end
        end
    endgenerate

    // interrupt and switch outputs
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            irq_reg <= 1'b0;
            o_switch_a_enable <= 1'b0;
            o_switch_b_enable <= 1'b0;
            o_switch_c_enable <= 1'b0;
        end
        else
        begin
            irq_reg <= |(pending_reg & arm_reg);
            o_switch_a_enable <= switch_en_reg[2];
            o_switch_b_enable <= switch_en_reg[1];
            o_switch_c_enable <= switch_en_reg[0];
        end
    end

    assign o_irq = irq_reg;

endmodule
